// file: core/lechc_pkg.sv
// package: register map, field layout and reset values of the lane error counter hold block
package lechc_pkg;
   localparam int          LECHC_LANES        = 3;
   localparam int          LECHC_TYPES        = 3;
   localparam int          LECHC_NUM_LINKS    = 2;
   localparam int          LECHC_CNT_W        = 8;
   localparam int          LECHC_AW           = 16;
   localparam int          LECHC_DW           = 32;
   // register indices; byte address is four times the index
   localparam logic [13:0] LECHC_IDX_LINK_PAGE = 14'h0300;
   localparam logic [13:0] LECHC_IDX_SOFT_RST  = 14'h0475;
   localparam logic [13:0] LECHC_IDX_HOLD_L2   = 14'h048A;
   localparam logic [13:0] LECHC_IDX_HOLD_L3   = 14'h048B;
   localparam logic [13:0] LECHC_IDX_HOLD_L4   = 14'h048C;
   localparam logic [13:0] LECHC_IDX_CNT_CLR   = 14'h04A0;
   localparam logic [13:0] LECHC_IDX_CNT_L2    = 14'h04A1;
   localparam logic [13:0] LECHC_IDX_CNT_L3    = 14'h04A2;
   localparam logic [13:0] LECHC_IDX_CNT_L4    = 14'h04A3;
   localparam logic [13:0] LECHC_IDX_IRQ_STAT  = 14'h04A4;
   localparam logic [13:0] LECHC_IDX_IRQ_MASK  = 14'h04A5;
   // fields
   localparam int          LECHC_SOFT_RST_BIT = 3;
   localparam int          LECHC_T_UCS        = 2;
   localparam int          LECHC_T_NIT        = 1;
   localparam int          LECHC_T_BD         = 0;
   localparam int          LECHC_EV_W         = LECHC_LANES * LECHC_TYPES;
   // reset values and counter marks
   localparam logic [2:0]  LECHC_HOLD_RST     = 3'h7;
   localparam logic        LECHC_SOFT_RST_RST = 1'b0;
   localparam logic [8:0]  LECHC_MASK_RST     = 9'h000;
   localparam logic [7:0]  LECHC_CNT_TC       = 8'hFF;
   localparam logic [7:0]  LECHC_CNT_PRE_TC   = 8'hFE;
endpackage

// file: core/lechc_err_counter.sv
// one lane error counter with terminal count hold or roll over
`timescale 1ns/1ps
`default_nettype none
module lechc_err_counter #(
   parameter int W = 8
) (
   input  wire logic         mclk_i,
   input  wire logic         reset_n_i,
   input  wire logic         ce_i,
   input  wire logic         inc_i,
   input  wire logic         clr_i,
   input  wire logic         hold_i,
   output logic     [W-1:0] count_o
);
   logic [W-1:0] count_r;

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         count_r <= '0;
      end else if (ce_i) begin
         if (clr_i) begin
            count_r <= '0;
         end else if (inc_i) begin
            if (hold_i && (count_r == {W{1'b1}})) begin
               count_r <= count_r;             // see R1
            end else begin
               count_r <= count_r + {{(W-1){1'b0}}, 1'b1}; // see R2 see R8
            end
         end
      end
   end

   assign count_o = count_r;
endmodule
`default_nettype wire

// file: core/lechc_top.sv
// top: apb register bank with paged hold enables, lane error counters and interrupt
// Function
// R1: with a hold bit set, its counter stops at 0xFF until software clears it.
// R2: with a hold bit clear, its counter rolls over to zero and keeps counting.
// R3: hold bit 2 steers the control symbol counter, bit 1 not-in-table, bit 0 disparity.
// R4: software changes hold fields only while the deserializer soft reset bit 3 of 0x475 is set; hold writes do not check soft_rst_r.
// R5: hold reads and writes go to the link chosen by the page register 0x300, one copy per link.
// R6: one hold register per lane, lanes 2, 3 and 4 at 0x48A, 0x48B and 0x48C, field in bits 2:0.
// R7: hold fields reset to 0x7, bits 7:3 read zero and ignore writes.
// R8: each counter is eight bits and counts one per detected error of its type.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module lechc_top #(
   parameter int NUM_LINKS = lechc_pkg::LECHC_NUM_LINKS
) (
   input  wire logic                           mclk_i,
   input  wire logic                           reset_n_i,
   input  wire logic                           ce_i,
   input  wire logic                           psel_i,
   input  wire logic                           penable_i,
   input  wire logic                           pwrite_i,
   input  wire logic [lechc_pkg::LECHC_AW-1:0] paddr_i,
   input  wire logic [lechc_pkg::LECHC_DW-1:0] pwdata_i,
   output logic      [lechc_pkg::LECHC_DW-1:0] prdata_o,
   output logic                                pready_o,
   output logic                                pslverr_o,
   input  wire logic [NUM_LINKS*3-1:0]         unexpected_control_symbol_err_i,
   input  wire logic [NUM_LINKS*3-1:0]         not_in_table_err_i,
   input  wire logic [NUM_LINKS*3-1:0]         bad_disparity_err_i,
   output logic                                lane_deserializer_block_soft_reset_o,
   output logic                                irq_o
);
   import lechc_pkg::*;

   localparam int PW = (NUM_LINKS > 1) ? $clog2(NUM_LINKS) : 1;
   localparam int NC = NUM_LINKS * LECHC_EV_W;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // state
   logic [2:0]            hold_r [NUM_LINKS][LECHC_LANES];
   logic [PW-1:0]         page_r;
   logic                  soft_rst_r;
   logic [LECHC_EV_W-1:0] stat_r;
   logic [LECHC_EV_W-1:0] mask_r;
   logic                  irq_r;
   logic                  pready_r;
   logic                  pslverr_r;
   logic [LECHC_DW-1:0]   prdata_r;
   logic [LECHC_DW-1:0]   rdata_nxt;
   logic                  rerr_nxt;
   logic [13:0]           idx;
   logic                  acc;
   logic                  wr_fire;
   logic [LECHC_LANES-1:0] wr_hold;
   logic [7:0]            cnt_w  [NC];
   logic [NC-1:0]         inc_w;
   logic [NC-1:0]         clr_w;
   logic [NC-1:0]         hold_w;
   logic [NC-1:0]         ev_w;
   logic [LECHC_EV_W-1:0] ev_lane;

   assign idx     = paddr_i[15:2];
   assign acc     = psel_i && penable_i;
   assign wr_fire = acc && pwrite_i && pready_r;
   assign wr_hold[0] = wr_fire && (idx == LECHC_IDX_HOLD_L2); // see R6
   assign wr_hold[1] = wr_fire && (idx == LECHC_IDX_HOLD_L3); // see R6
   assign wr_hold[2] = wr_fire && (idx == LECHC_IDX_HOLD_L4); // see R6

   ////////////////////////////////////////////////////////////////////////////////////////////
   // apb slave: one wait state, read data captured with pready
   always_comb begin
      rdata_nxt = '0;
      rerr_nxt  = 1'b0;
      unique case (idx)
         LECHC_IDX_LINK_PAGE: rdata_nxt[PW-1:0] = page_r;
         LECHC_IDX_SOFT_RST:  rdata_nxt[LECHC_SOFT_RST_BIT] = soft_rst_r;
         LECHC_IDX_HOLD_L2:   rdata_nxt[2:0] = hold_r[page_r][0]; // see R5 see R7
         LECHC_IDX_HOLD_L3:   rdata_nxt[2:0] = hold_r[page_r][1]; // see R5 see R7
         LECHC_IDX_HOLD_L4:   rdata_nxt[2:0] = hold_r[page_r][2]; // see R5 see R7
         LECHC_IDX_CNT_CLR:   rdata_nxt = '0;
         LECHC_IDX_CNT_L2:    rdata_nxt[23:0] = {cnt_w[page_r*9+2], cnt_w[page_r*9+1],
                                                 cnt_w[page_r*9]};
         LECHC_IDX_CNT_L3:    rdata_nxt[23:0] = {cnt_w[page_r*9+5], cnt_w[page_r*9+4],
                                                 cnt_w[page_r*9+3]};
         LECHC_IDX_CNT_L4:    rdata_nxt[23:0] = {cnt_w[page_r*9+8], cnt_w[page_r*9+7],
                                                 cnt_w[page_r*9+6]};
         LECHC_IDX_IRQ_STAT:  rdata_nxt[LECHC_EV_W-1:0] = stat_r;
         LECHC_IDX_IRQ_MASK:  rdata_nxt[LECHC_EV_W-1:0] = mask_r;
         default:             rerr_nxt = 1'b1;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= '0;
      end else if (ce_i) begin
         pready_r  <= acc && !pready_r;
         pslverr_r <= acc && !pready_r && rerr_nxt;
         if (acc && !pready_r) begin
            prdata_r <= pwrite_i ? '0 : rdata_nxt;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // page and soft reset control
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         page_r     <= '0;
         soft_rst_r <= LECHC_SOFT_RST_RST;
      end else if (ce_i) begin
         if (wr_fire && (idx == LECHC_IDX_LINK_PAGE)) begin
            page_r <= pwdata_i[PW-1:0];        // see R5
         end
         if (wr_fire && (idx == LECHC_IDX_SOFT_RST)) begin
            soft_rst_r <= pwdata_i[LECHC_SOFT_RST_BIT]; // see R4
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // hold fields, one copy per link
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         for (int l = 0; l < NUM_LINKS; l++) begin
            for (int k = 0; k < LECHC_LANES; k++) begin
               hold_r[l][k] <= LECHC_HOLD_RST;    // see R7
            end
         end
      end else if (ce_i) begin
         for (int k = 0; k < LECHC_LANES; k++) begin
            if (wr_hold[k]) begin
               hold_r[page_r][k] <= pwdata_i[2:0]; // see R5 see R7
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // counters: index (link*3 + lane)*3 + type
   genvar gl, gk, gt;
   generate
      for (gl = 0; gl < NUM_LINKS; gl++) begin : g_link
         for (gk = 0; gk < LECHC_LANES; gk++) begin : g_lane
            for (gt = 0; gt < LECHC_TYPES; gt++) begin : g_type
               localparam int C = (gl * LECHC_LANES + gk) * LECHC_TYPES + gt;
               if (gt == LECHC_T_UCS) begin : g_ucs
                  assign inc_w[C] = unexpected_control_symbol_err_i[gl*3+gk]; // see R8
               end else if (gt == LECHC_T_NIT) begin : g_nit
                  assign inc_w[C] = not_in_table_err_i[gl*3+gk];              // see R8
               end else begin : g_bd
                  assign inc_w[C] = bad_disparity_err_i[gl*3+gk];             // see R8
               end
               assign hold_w[C] = hold_r[gl][gk][gt]; // see R3
               assign clr_w[C]  = wr_fire && (idx == LECHC_IDX_CNT_CLR) &&
                                  (page_r == PW'(gl)) && pwdata_i[gk*3+gt];
               assign ev_w[C]   = inc_w[C] && !clr_w[C] && (cnt_w[C] == LECHC_CNT_PRE_TC);

               lechc_err_counter #(
                  .W (LECHC_CNT_W)
               ) u_cnt (
                  .mclk_i    (mclk_i),
                  .reset_n_i (reset_n_i),
                  .ce_i      (ce_i),
                  .inc_i     (inc_w[C]),
                  .clr_i     (clr_w[C]),
                  .hold_i    (hold_w[C]),
                  .count_o   (cnt_w[C])
               );

               AST_HOLD_SAT: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see R1
                  (ce_i && hold_w[C] && inc_w[C] && !clr_w[C] && cnt_w[C] == LECHC_CNT_TC)
                  |=> (cnt_w[C] == LECHC_CNT_TC))
                  else $error("held counter left terminal count");
               AST_ROLL_OVER: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see R2
                  (ce_i && !hold_w[C] && inc_w[C] && !clr_w[C] && cnt_w[C] == LECHC_CNT_TC)
                  |=> (cnt_w[C] == 8'h00))
                  else $error("counter did not roll over");
               AST_COUNT_ONE: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see R8
                  (ce_i && inc_w[C] && !clr_w[C] && cnt_w[C] != LECHC_CNT_TC)
                  |=> (cnt_w[C] == $past(cnt_w[C]) + 8'h01))
                  else $error("counter did not advance by one");
               AST_HOLD_MAP: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see R3
                  (ce_i && inc_w[C] && !clr_w[C] && cnt_w[C] == LECHC_CNT_TC &&
                   hold_r[gl][gk][gt]) |=> ##1 (cnt_w[C] == LECHC_CNT_TC) || $past(clr_w[C]) ||
                   $past(!ce_i) || $past(inc_w[C] && !hold_w[C]))
                  else $error("hold bit does not steer its own counter");
               AST_CLR_ZERO: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see R1
                  (ce_i && clr_w[C]) |=> (cnt_w[C] == 8'h00))
                  else $error("counter clear did not reach zero");
               AST_CE_FREEZE: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see R8
                  !ce_i |=> $stable(cnt_w[C]))
                  else $error("counter moved while clock enable was low");
            end
            AST_PAGE_OTHER: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see R5
               (ce_i && wr_hold[gk] && page_r != PW'(gl)) |=> $stable(hold_r[gl][gk]))
               else $error("hold write leaked into another link");
            AST_PAGE_WRITE: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see R6
               (ce_i && wr_hold[gk] && page_r == PW'(gl))
               |=> (hold_r[gl][gk] == $past(pwdata_i[2:0])))
               else $error("hold write missed its lane");
            AST_HOLD_RESET: assert property (@(posedge mclk_i) // see R7
               $past(!reset_n_i) |-> (hold_r[gl][gk] == LECHC_HOLD_RST))
               else $error("hold field not 0x7 after reset");
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////////////////
   // interrupt: terminal count events, sticky, write one to clear, set wins
   always_comb begin
      ev_lane = '0;
      for (int c = 0; c < NC; c++) begin
         ev_lane[c % LECHC_EV_W] = ev_lane[c % LECHC_EV_W] | ev_w[c];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         stat_r <= '0;
      end else if (ce_i) begin
         if (wr_fire && (idx == LECHC_IDX_IRQ_STAT)) begin
            stat_r <= (stat_r & ~pwdata_i[LECHC_EV_W-1:0]) | ev_lane;
         end else begin
            stat_r <= stat_r | ev_lane;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         mask_r <= LECHC_MASK_RST;
      end else if (ce_i && wr_fire && (idx == LECHC_IDX_IRQ_MASK)) begin
         mask_r <= pwdata_i[LECHC_EV_W-1:0];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         irq_r <= 1'b0;
      end else if (ce_i) begin
         irq_r <= |(stat_r & mask_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // outputs
   assign prdata_o  = prdata_r;
   assign pready_o  = pready_r;
   assign pslverr_o = pslverr_r;
   assign irq_o     = irq_r;
   assign lane_deserializer_block_soft_reset_o = soft_rst_r;

   AST_HOLD_RSVD: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see R7
      (ce_i && acc && !pready_r && !pwrite_i && idx >= LECHC_IDX_HOLD_L2 &&
       idx <= LECHC_IDX_HOLD_L4) |=> (prdata_o[31:3] == 29'h0 && pready_o))
      else $error("hold read shows reserved bits");
   AST_CNT_READ: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see R3
      (ce_i && acc && !pready_r && !pwrite_i && idx == LECHC_IDX_CNT_L2)
      |=> (prdata_o[23:16] == $past(cnt_w[page_r*9+LECHC_T_UCS])))
      else $error("control symbol count not in bits 23:16");

   ////////////////////////////////////////////////////////////////////////////////////////////
   // bus, paging and interrupt checks
   AST_HOLD_READ: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see R5
      (ce_i && acc && !pready_r && !pwrite_i && idx == LECHC_IDX_HOLD_L3)
      |=> (prdata_o[2:0] == $past(hold_r[page_r][1])))
      else $error("hold read not taken from the paged copy");
   AST_SOFT_RST_OUT: assert property (@(posedge mclk_i) disable iff (!reset_n_i) // see R4
      (ce_i && wr_fire && idx == LECHC_IDX_SOFT_RST)
      |=> (lane_deserializer_block_soft_reset_o == $past(pwdata_i[LECHC_SOFT_RST_BIT])))
      else $error("soft reset output missed its write");
   AST_PREADY_ONE: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (ce_i && pready_o) |=> !pready_o)
      else $error("pready stood for more than one cycle");
   AST_SLVERR: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (ce_i && acc && !pready_r && rerr_nxt) |=> (pslverr_o && pready_o))
      else $error("unmapped access not refused");
   AST_STAT_SET: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (ce_i && |ev_lane) |=> ((stat_r & $past(ev_lane)) == $past(ev_lane)))
      else $error("terminal count event lost against a clear");
   AST_IRQ_LEVEL: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      ce_i |=> (irq_o == $past(|(stat_r & mask_r))))
      else $error("interrupt does not follow masked status");
   AST_MASK_HOLD: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      !ce_i |=> ($stable(mask_r) && $stable(page_r) && $stable(stat_r)))
      else $error("state moved while clock enable was low");

   COV_HOLD_WRITE: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
      wr_hold[1] && soft_rst_r);
   COV_PAGE1_WRITE: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
      wr_hold[0] && page_r != '0);
   COV_SATURATE: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
      |ev_w ##1 irq_r [*2]);
   COV_STAT_CLEAR: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
      wr_fire && (idx == LECHC_IDX_IRQ_STAT) && |stat_r);
   COV_CE_LOW: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
      !ce_i && |inc_w);
endmodule
`default_nettype wire

// file: bench/lechc_top_tb.sv
// testbench: apb access, paged hold fields, counter hold and roll over, interrupt
`timescale 1ns/1ps
`default_nettype none
module lechc_top_tb;
   import lechc_pkg::*;
   logic        mclk_i;
   logic        reset_n_i;
   logic        ce;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [15:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [5:0]  ucs_err;
   logic [5:0]  nit_err;
   logic [5:0]  bd_err;
   logic        soft_rst;
   logic        irq;
   logic [31:0] seed;
   logic [31:0] rd;
   logic        er;
   logic [31:0] ex;
   int          fail_count;
   int          checks;
   int          n;
   int          lane;
   int          link;

   lechc_top #(.NUM_LINKS(2)) i_lechc_top (
      .mclk_i(mclk_i), .reset_n_i(reset_n_i), .ce_i(ce), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .unexpected_control_symbol_err_i(ucs_err), .not_in_table_err_i(nit_err),
      .bad_disparity_err_i(bd_err), .lane_deserializer_block_soft_reset_o(soft_rst),
      .irq_o(irq));

   ////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      mclk_i = 1'b0;
      forever #4 mclk_i = ~mclk_i;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // expected count after total errors, with or without terminal hold
   function automatic logic [7:0] cnt_exp(input logic hold, input int total);
      if (hold && total >= 255) return LECHC_CNT_TC;
      return 8'(total % 256);
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [13:0] idx, input logic [31:0] wd);
      int k;
      @(posedge mclk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge mclk_i);
      penable <= 1'b1;
      k = 0;
      @(posedge mclk_i);
      while (pready !== 1'b1 && k < 50) begin
         @(posedge mclk_i);
         k++;
      end
      if (pready !== 1'b1) begin
         fail_count++;
         $display("FAIL %0t no pready", $time);
         tally_and_finish();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [13:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chk(rd, exp);
      chk({31'h0, er}, 32'h0);
   endtask

   // hold the error lines of the given lanes high for exactly n cycles
   task automatic errs(input logic [5:0] m, input int cyc);
      repeat (cyc) begin
         @(posedge mclk_i);
         ucs_err <= m;
         nit_err <= m;
         bd_err <= m;
      end
      @(posedge mclk_i);
      ucs_err <= 6'h00;
      nit_err <= 6'h00;
      bd_err <= 6'h00;
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      seed = 32'hDA89;
      fail_count = 0;
      checks = 0;
      reset_n_i = 1'b0;
      ce = 1'b1;
      {psel, penable, pwrite} = 3'h0;
      paddr = 16'h0000;
      pwdata = 32'h0;
      {ucs_err, nit_err, bd_err} = 18'h0;
      repeat (16) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      for (int p = 0; p < 2; p++) begin
         apb(1'b1, LECHC_IDX_LINK_PAGE, 32'(p));
         for (int l = 0; l < 3; l++) rdchk(LECHC_IDX_HOLD_L2 + 14'(l), 32'h7);
      end
      apb(1'b0, 14'h0010, 32'h0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      $display("test reset values done");
      ex = 32'(rnd() % 8);
      apb(1'b1, LECHC_IDX_SOFT_RST, 32'h8);
      @(posedge mclk_i);
      chk({31'h0, soft_rst}, 32'h1);
      apb(1'b1, LECHC_IDX_HOLD_L3, 32'hFFFFFFF8 | ex);
      rdchk(LECHC_IDX_HOLD_L3, ex);
      apb(1'b1, LECHC_IDX_LINK_PAGE, 32'h0);
      rdchk(LECHC_IDX_HOLD_L3, 32'h7);
      $display("test paging done");
      for (int t = 0; t < 3; t++) begin
         lane = int'(rnd() % 3);
         link = int'(rnd() % 2);
         apb(1'b1, LECHC_IDX_LINK_PAGE, 32'(link));
         apb(1'b1, LECHC_IDX_SOFT_RST, 32'h8);
         apb(1'b1, LECHC_IDX_HOLD_L2 + 14'(lane), 32'h1 << t);
         apb(1'b1, LECHC_IDX_SOFT_RST, 32'h0);
         @(posedge mclk_i);
         chk({31'h0, soft_rst}, 32'h0);
         apb(1'b1, LECHC_IDX_CNT_CLR, 32'h1FF);
         n = int'(rnd() % 250) + 1;
         errs(6'h1 << (link * 3 + lane), n);
         rdchk(LECHC_IDX_CNT_L2 + 14'(lane), {8'h0, 8'(n), 8'(n), 8'(n)});
         ce <= 1'b0;
         errs(6'h1 << (link * 3 + lane), 3);
         ce <= 1'b1;
         rdchk(LECHC_IDX_CNT_L2 + 14'(lane), {8'h0, 8'(n), 8'(n), 8'(n)});
         errs(6'h1 << (link * 3 + lane), 257 - n);
         ex = 32'h0;
         for (int k = 0; k < 3; k++) ex = ex | (32'(cnt_exp(k == t, 257)) << (8 * k));
         rdchk(LECHC_IDX_CNT_L2 + 14'(lane), ex);
         rdchk(LECHC_IDX_IRQ_STAT, 32'h7 << (lane * 3));
         apb(1'b1, LECHC_IDX_IRQ_MASK, (t == 0) ? 32'h0 : 32'h1 << (lane * 3 + t));
         repeat (2) @(posedge mclk_i);
         chk({31'h0, irq}, (t == 0) ? 32'h0 : 32'h1);
         apb(1'b1, LECHC_IDX_IRQ_STAT, 32'h1FF);
         repeat (2) @(posedge mclk_i);
         chk({31'h0, irq}, 32'h0);
         rdchk(LECHC_IDX_IRQ_STAT, 32'h0);
         $display("test hold type %0d lane %0d link %0d done", t, lane, link);
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire
